/* File: verilog/biss_slave_pkg.sv */
`default_nettype none
package biss_slave_pkg;

    // Timing at the 25 MHz system clock
    localparam int CLK_NS = 40;
    localparam int BUSY_NS = 5500;
    localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam int TOUT_NS = 15000;
    localparam int TOUT_CYC = (TOUT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [8:0] BUSY_LOAD = 9'(BUSY_CYC);
    localparam logic [8:0] TOUT_LAST = 9'(TOUT_CYC - 1);

    // Single cycle data layout
    localparam int MT_W = 16;
    localparam int ST_W = 17;
    localparam int SCD_W = MT_W + ST_W + 2;
    localparam int SEND_W = SCD_W + 6 + 2;
    localparam logic [5:0] SEND_LAST = 6'(SEND_W);

    // Checksums
    localparam logic [6:0] CRC6_POLY = 7'h43;
    localparam logic [5:0] CRC6_INIT = 6'h00;
    localparam logic [4:0] CRC4_POLY = 5'h13;
    localparam logic [3:0] CRC4_INIT = 4'h0;

    // Control frame
    localparam logic [3:0] ZERO_RUN = 4'hE;
    localparam logic [2:0] SLAVE_ID = 3'h0;
    localparam logic [5:0] CF_CTS = 6'h01;
    localparam logic [5:0] CF_ID0 = 6'h02;
    localparam logic [5:0] CF_ID2 = 6'h04;
    localparam logic [5:0] CF_ADR0 = 6'h05;
    localparam logic [5:0] CF_ADR6 = 6'h0B;
    localparam logic [5:0] CF_HCRC0 = 6'h0C;
    localparam logic [5:0] CF_HCRC3 = 6'h0F;
    localparam logic [5:0] CF_R = 6'h10;
    localparam logic [5:0] CF_W = 6'h11;
    localparam logic [5:0] CF_DAT0 = 6'h12;
    localparam logic [5:0] CF_DAT7 = 6'h19;
    localparam logic [5:0] CF_DCRC0 = 6'h1A;
    localparam logic [5:0] CF_DCRC3 = 6'h1D;
    localparam logic [5:0] CF_ANS0 = 6'h1E;
    localparam logic [5:0] CF_ACRC3 = 6'h29;
    localparam logic [5:0] CF_STOP = 6'h2A;

    // Registers
    localparam logic [5:0] BANK_SEL_IDX = 6'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam int WR_W = 8 + 7 + 8;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_LATCH = 3'b001,
        S_ACK = 3'b011,
        S_SEND = 3'b010,
        S_TOUT = 3'b110
    } frame_state_t;

endpackage : biss_slave_pkg
`default_nettype wire

/* File: verilog/two_entry_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    logic [W-1:0] head_reg;
    logic [W-1:0] tail_reg;
    logic head_v_reg;
    logic tail_v_reg;
    wire push = in_valid & ~tail_v_reg;
    wire pop = head_v_reg & out_ready;

    // Both outputs come from flops so the stall path stays short
    assign in_ready = ~tail_v_reg;
    assign out_valid = head_v_reg;
    assign out_data = head_reg;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            head_v_reg <= 1'b0;
            tail_v_reg <= 1'b0;
            head_reg <= '0;
            tail_reg <= '0;
        end else if (pop && tail_v_reg) begin
            head_reg <= tail_reg;
            tail_reg <= in_data;
            tail_v_reg <= push;
        end else if (pop) begin
            head_reg <= in_data;
            head_v_reg <= push;
        end else if (push && !head_v_reg) begin
            head_reg <= in_data;
            head_v_reg <= 1'b1;
        end else if (push) begin
            tail_reg <= in_data;
            tail_v_reg <= 1'b1;
        end
    end

endmodule : two_entry_buffer
`default_nettype wire

/* File: verilog/biss_c_encoder_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Master clocks the link on its clock line; slave answers on its data line.
// - Position is captured at the first falling clock edge of each cycle.
// - First rising edge drives the data line low; held until data is ready.
// - When ready, a start bit of one goes out on a rising clock edge.
// - One slave control bit follows the start bit, then the single cycle data.
// - Send 16-bit count, 17-bit angle, fault, caution, 6-bit checksum, MSB first.
// - The checksum covers count, angle, fault and caution bits.
// - Six-bit checksum, polynomial 0x43, start value zero, sent inverted.
// - Data line held low for the timeout; master's control bit read then.
// - Both lines rest high between cycles.
// - Control frames collect one master and one slave bit per cycle.
// - A control frame starts after 14 zero master control bits, or at once after a clean stop.
// - Slave returns lock bits telling which slave numbers are busy.
// - After a write the slave returns the value read back from that register.
// - Every control frame closes with a zero stop bit.
// - Indices 0x00-0x3F reach the bank chosen at 0x40; above that, direct.
module biss_c_encoder_slave
    import biss_slave_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Link
    input wire logic ma_in,
    output logic slo_out,
    // Position source
    input wire logic [MT_W-1:0] multiturn_count,
    input wire logic [ST_W-1:0] singleturn_angle,
    input wire logic fault_in,
    input wire logic caution_in,
    // Banked register read
    output logic [7:0] bank_sel,
    output logic [5:0] bank_index,
    input wire logic [7:0] bank_rd_data,
    // Register write stream
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [7:0] wr_bank,
    output logic [6:0] wr_addr,
    output logic [7:0] wr_data
);

    function automatic logic [5:0] crc6_of(input logic [SCD_W-1:0] d);
        logic [5:0] c;
        logic fb;
        c = CRC6_INIT;
        for (int i = SCD_W - 1; i >= 0; i--) begin
            fb = c[5] ^ d[i];
            c = {c[4:0], 1'b0} ^ (fb ? CRC6_POLY[5:0] : 6'h00);
        end
        return c;
    endfunction : crc6_of

    function automatic logic [3:0] crc4_step(input logic [3:0] c,
                                             input logic b);
        return {c[2:0], 1'b0} ^ ((c[3] ^ b) ? CRC4_POLY[3:0] : 4'h0);
    endfunction : crc4_step

    function automatic logic [3:0] crc4_of8(input logic [7:0] d);
        logic [3:0] c;
        c = CRC4_INIT;
        for (int i = 7; i >= 0; i--) begin
            c = crc4_step(c, d[i]);
        end
        return c;
    endfunction : crc4_of8

    function automatic logic in_range(input logic [5:0] v,
                                      input logic [5:0] lo,
                                      input logic [5:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction : in_range

    // Clock line synchroniser and edge finder
    logic ma_meta_reg;
    logic ma_sync_reg;
    logic ma_prev_reg;
    wire ma_rise = ma_sync_reg & ~ma_prev_reg;
    wire ma_fall = ~ma_sync_reg & ma_prev_reg;
    wire ma_edge = ma_rise | ma_fall;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ma_meta_reg <= 1'b1;
            ma_sync_reg <= 1'b1;
            ma_prev_reg <= 1'b1;
        end else begin
            ma_meta_reg <= ma_in;
            ma_sync_reg <= ma_meta_reg;
            ma_prev_reg <= ma_sync_reg;
        end
    end

    // Frame sequencer
    frame_state_t state_reg;
    frame_state_t state_next;
    logic slo_reg;
    logic [8:0] idle_cnt_reg;
    logic [8:0] busy_cnt_reg;
    logic [SEND_W-1:0] send_sh_reg;
    logic [5:0] send_cnt_reg;
    logic cds_bit;

    wire [SCD_W-1:0] scd_word = {multiturn_count, singleturn_angle,
                                 fault_in, caution_in};
    wire [5:0] scd_crc = ~crc6_of(scd_word);
    wire busy_done = busy_cnt_reg == 9'h000;
    wire sent_all = send_cnt_reg == SEND_LAST;
    wire tout_hit = idle_cnt_reg == TOUT_LAST;
    wire latch_now = (state_reg == S_IDLE) & ma_fall;
    wire shift_now = ma_rise & (((state_reg == S_ACK) & busy_done) |
                                ((state_reg == S_SEND) & ~sent_all));
    wire cdm_take = (state_reg == S_TOUT) & tout_hit;
    // Control bit travels inverted on the line
    wire cdm = ~ma_sync_reg;

    // Timer restarts on every clock edge so it measures from the last one
    wire [8:0] idle_cnt_next = (state_reg == S_IDLE || ma_edge) ? 9'h000 :
                               idle_cnt_reg + 9'h001;
    wire [8:0] busy_cnt_next = latch_now ? BUSY_LOAD :
                               busy_done ? 9'h000 :
                               busy_cnt_reg - 9'h001;
    wire [SEND_W-1:0] send_sh_next =
        latch_now ? {1'b1, cds_bit, scd_word, scd_crc} :
        shift_now ? {send_sh_reg[SEND_W-2:0], 1'b0} : send_sh_reg;
    wire [5:0] send_cnt_next = latch_now ? 6'h00 :
                               shift_now ? send_cnt_reg + 6'h01 :
                               send_cnt_reg;
    wire slo_next =
        tout_hit ? 1'b1 :
        ((state_reg == S_LATCH) & ma_rise) ? 1'b0 :
        shift_now ? send_sh_reg[SEND_W-1] :
        ((state_reg == S_SEND) & ma_rise) ? 1'b0 :
        slo_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: if (ma_fall) state_next = S_LATCH;
            S_LATCH: if (ma_rise) state_next = S_ACK;
            S_ACK: if (ma_rise && busy_done) state_next = S_SEND;
            S_SEND: if (ma_rise && sent_all) state_next = S_TOUT;
            S_TOUT: state_next = S_TOUT;
            default: state_next = S_IDLE;
        endcase
        // A master that stops clocking mid-frame also ends it here
        if (tout_hit) state_next = S_IDLE;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_reg <= S_IDLE;
            slo_reg <= 1'b1;
            idle_cnt_reg <= 9'h000;
            busy_cnt_reg <= 9'h000;
            send_sh_reg <= '0;
            send_cnt_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            slo_reg <= slo_next;
            idle_cnt_reg <= idle_cnt_next;
            busy_cnt_reg <= busy_cnt_next;
            send_sh_reg <= send_sh_next;
            send_cnt_reg <= send_cnt_next;
        end
    end

    assign slo_out = slo_reg;

    // Control frame state
    logic ctl_on_reg;
    logic [5:0] idx_reg;
    logic [3:0] zero_run_reg;
    logic [3:0] crc_reg;
    logic [2:0] id_reg;
    logic [6:0] adr_reg;
    logic rd_reg;
    logic wr_reg;
    logic [7:0] wdat_reg;
    logic [10:0] ans_sh_reg;
    logic [7:0] dir_mem [0:63];
    logic buf_in_ready;

    wire in_id = in_range(idx_reg, CF_ID0, CF_ID2);
    wire in_adr = in_range(idx_reg, CF_ADR0, CF_ADR6);
    wire in_dat = in_range(idx_reg, CF_DAT0, CF_DAT7);
    wire in_chk = in_range(idx_reg, CF_HCRC0, CF_HCRC3) |
                  in_range(idx_reg, CF_DCRC0, CF_DCRC3);
    wire in_ans = in_range(idx_reg, CF_ANS0 + 6'h01, CF_ACRC3);
    wire bit_bad =
        ((idx_reg == CF_CTS) & ~cdm) |
        (in_chk & (cdm == crc_reg[3])) |
        ((idx_reg == CF_W) & ((id_reg != SLAVE_ID) | (rd_reg == cdm))) |
        ((idx_reg == CF_STOP) & cdm);
    // New frame needs room for its possible write before it is accepted
    wire frame_go = ~ctl_on_reg & cdm & (zero_run_reg >= ZERO_RUN) &
                    buf_in_ready;
    wire ctl_step = cdm_take & ctl_on_reg;
    wire do_write = ctl_step & ~bit_bad & (idx_reg == CF_DCRC3) &
                    wr_reg;

    // Register read selection
    wire [7:0] rd_mux = adr_reg[6] ? dir_mem[adr_reg[5:0]] :
                        bank_rd_data;
    wire [11:0] ans_word = {rd_mux, ~crc4_of8(rd_mux)};
    wire ans_load = latch_now & ctl_on_reg & (idx_reg == CF_ANS0);

    always_comb begin
        cds_bit = 1'b0;
        if (ctl_on_reg && in_id) begin
            cds_bit = idx_reg == CF_ID2;
        end else if (ctl_on_reg && idx_reg == CF_ANS0) begin
            cds_bit = ans_word[11];
        end else if (ctl_on_reg && in_ans) begin
            cds_bit = ans_sh_reg[10];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ans_sh_reg <= '0;
        end else if (ans_load) begin
            ans_sh_reg <= ans_word[10:0];
        end else if (latch_now && ctl_on_reg && in_ans) begin
            ans_sh_reg <= {ans_sh_reg[9:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctl_on_reg <= 1'b0;
            idx_reg <= 6'h00;
            zero_run_reg <= 4'h0;
            crc_reg <= CRC4_INIT;
        end else if (frame_go && cdm_take) begin
            ctl_on_reg <= 1'b1;
            idx_reg <= CF_CTS;
            crc_reg <= CRC4_INIT;
        end else if (cdm_take && !ctl_on_reg) begin
            zero_run_reg <= cdm ? 4'h0 :
                (zero_run_reg == ZERO_RUN ? ZERO_RUN :
                 zero_run_reg + 4'h1);
        end else if (ctl_step && (bit_bad || idx_reg == CF_STOP)) begin
            // A clean stop lets the next frame open at once
            ctl_on_reg <= 1'b0;
            zero_run_reg <= bit_bad ? 4'h0 : ZERO_RUN;
        end else if (ctl_step) begin
            idx_reg <= idx_reg + 6'h01;
            if (in_id || in_adr || in_dat) begin
                crc_reg <= crc4_step(crc_reg, cdm);
            end else if (in_chk) begin
                crc_reg <= {crc_reg[2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            id_reg <= 3'h0;
            adr_reg <= 7'h00;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            wdat_reg <= 8'h00;
        end else if (ctl_step) begin
            if (in_id) id_reg <= {id_reg[1:0], cdm};
            if (in_adr) adr_reg <= {adr_reg[5:0], cdm};
            if (idx_reg == CF_R) rd_reg <= cdm;
            if (idx_reg == CF_W) wr_reg <= cdm;
            if (in_dat) wdat_reg <= {wdat_reg[6:0], cdm};
        end
    end

    // Direct registers; entry 0 is the bank selector
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int i = 0; i < 64; i++) begin
                dir_mem[i] <= DIR_RESET;
            end
        end else if (do_write && adr_reg[6]) begin
            dir_mem[adr_reg[5:0]] <= wdat_reg;
        end
    end

    assign bank_sel = dir_mem[BANK_SEL_IDX];
    assign bank_index = adr_reg[5:0];

    // Every accepted write is also streamed out; the user keeps banks
    logic [WR_W-1:0] wr_word;

    two_entry_buffer #(
        .W(WR_W)
    ) u_wr_buf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(do_write),
        .in_ready(buf_in_ready),
        .in_data({dir_mem[BANK_SEL_IDX], adr_reg, wdat_reg}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_word)
    );

    assign wr_bank = wr_word[WR_W-1 -: 8];
    assign wr_addr = wr_word[14:8];
    assign wr_data = wr_word[7:0];

endmodule : biss_c_encoder_slave
`default_nettype wire

/* File: verification/biss_slave_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module biss_slave_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Link
    input wire logic ma_in,
    input wire logic slo_out,
    // Register side
    input wire logic [7:0] bank_sel,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [7:0] wr_bank,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic ma_reg;
    logic [9:0] rise_age_reg;
    logic [9:0] edge_age_reg;
    logic [9:0] hi_age_reg;
    wire ma_rise = ma_in && !ma_reg;
    // Ages saturate so a long idle spell never wraps back into range
    wire [9:0] rise_up = rise_age_reg + {9'h000, rise_age_reg != 10'h3FF};
    wire [9:0] edge_up = edge_age_reg + {9'h000, edge_age_reg != 10'h3FF};
    wire [9:0] hi_up = hi_age_reg + {9'h000, hi_age_reg != 10'h3FF};
    always_ff @(posedge clk_sys) begin
        ma_reg <= ma_in;
        rise_age_reg <= (!resetn || ma_rise) ? 10'h000 : rise_up;
        edge_age_reg <= (!resetn || ma_in != ma_reg) ? 10'h000 : edge_up;
        hi_age_reg <= (!resetn || !slo_out) ? 10'h000 : hi_up;
    end
    a_reset_quiet: assert property (disable iff (1'b0)
        !resetn |=> slo_out && !wr_valid && bank_sel == 8'h00)
        else $error("outputs not at rest after reset");
    a_ack_low: assert property ($fell(ma_in) && hi_age_reg > 10'h064
        |-> ##[1:12] ma_rise ##[1:6] !slo_out)
        else $error("no acknowledge after first rise");
    a_bit_on_rise: assert property ($changed(slo_out)
        |-> rise_age_reg <= 10'h006 || edge_age_reg >= 10'h145)
        else $error("data line moved away from a clock rise");
    a_tout_window: assert property ($rose(slo_out)
        && rise_age_reg > 10'h006
        |-> edge_age_reg >= 10'h145 && edge_age_reg <= 10'h1C2)
        else $error("timeout ended outside its window");
    a_idle_high: assert property (edge_age_reg > 10'h1C2 |-> slo_out)
        else $error("data line not high at rest");
    a_wr_hold: assert property (wr_valid && !wr_ready
        |=> wr_valid && $stable({wr_bank, wr_addr, wr_data}))
        else $error("stalled write word lost or changed");
    a_bank_at_end: assert property ($changed(bank_sel)
        |-> edge_age_reg >= 10'h145 ##[0:2] wr_valid)
        else $error("bank select moved outside a frame end");
    a_push_at_end: assert property ($rose(wr_valid)
        |-> edge_age_reg >= 10'h145)
        else $error("write word appeared outside a frame end");
endmodule : biss_slave_sva
`default_nettype wire

/* File: verification/biss_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module biss_master_model (
    // Link
    output var logic ma,
    input wire logic slo
);
    // 3.125 MHz: in range, and fast enough for the 50 us cycle
    localparam int HALF_NS = 160;
    initial ma = 1'b1;
    task automatic tick(output logic b);
        #HALF_NS ma = 1'b0;
        #HALF_NS b = slo;
        ma = 1'b1;
    endtask : tick
    // One cycle; ok drops when the slave misses a deadline
    task automatic frame(input logic cdm, output logic cds,
        output logic [34:0] scd, output logic [5:0] crc, output logic ok);
        realtime t0;
        logic [41:0] bits;
        int n;
        t0 = $realtime;
        ok = 1'b1;
        n = 0;
        #10 ma = 1'b0;
        #HALF_NS ma = 1'b1;
        do begin
            tick(bits[0]);
            n++;
        end while (bits[0] !== 1'b1 && n < 40);
        ok &= n < 40;
        for (int i = 41; i >= 0; i--)
            tick(bits[i]);
        #HALF_NS ma = !cdm;
        #HALF_NS ok &= slo === 1'b0;
        n = 0;
        while (slo !== 1'b1 && n < 500) begin
            #40 n++;
        end
        ok &= n < 500;
        ma = 1'b1;
        #(t0 + 50000.0 - $realtime);
        {cds, scd, crc} = bits;
    endtask : frame
endmodule : biss_master_model
`default_nettype wire

/* File: verification/test_biss_c_encoder_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %0h want %0h", $time, g, e); end end
module test_biss_c_encoder_slave
    import biss_slave_pkg::*;
;
    localparam logic [6:0] ADR = 7'h40;
    localparam logic [7:0] DAT = 8'h5A;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ma_in;
    logic slo_out;
    logic [34:0] pos = 35'h2A5C31E7B;
    logic [7:0] bank_rd_data = 8'hC3;
    logic [7:0] bank_sel;
    logic [5:0] bank_index;
    logic wr_valid;
    logic wr_ready = 1'b0;
    logic [7:0] wr_bank;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [47:0] cf;
    logic [47:0] ecds;
    int checked = 0;
    int err_count = 0;
    biss_c_encoder_slave dut (
        .clk_sys, .resetn, .ma_in, .slo_out,
        .multiturn_count(pos[34:19]), .singleturn_angle(pos[18:2]),
        .fault_in(pos[1]), .caution_in(pos[0]),
        .bank_sel, .bank_index, .bank_rd_data,
        .wr_valid, .wr_ready, .wr_bank, .wr_addr, .wr_data
    );
    biss_master_model mst (.ma(ma_in), .slo(slo_out));
    function automatic logic [5:0] crc6(input logic [34:0] d);
        logic [5:0] c = 6'h00;
        for (int i = 34; i >= 0; i--)
            c = {c[4:0], 1'b0} ^ (c[5] ^ d[i] ? 6'h03 : 6'h00);
        return c;
    endfunction : crc6
    function automatic logic [3:0] crc4(input logic [9:0] d, input int n);
        logic [3:0] c = 4'h0;
        for (int i = n - 1; i >= 0; i--)
            c = {c[2:0], 1'b0} ^ (c[3] ^ d[i] ? 4'h3 : 4'h0);
        return c;
    endfunction : crc4
    task automatic close_out;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    initial forever #20 clk_sys = ~clk_sys;
    initial begin
        #4000000;
        err_count++;
        close_out();
    end
    initial begin
        logic cds;
        logic [34:0] scd;
        logic [5:0] crc;
        logic ok;
        logic [34:0] want;
        // A clean stop lets a new frame open at once; the second frame
        // is followed as far as its lock bits
        cf = {2'b11, 3'b000, ADR, ~crc4({3'b000, ADR}, 10), 2'b01, DAT,
            ~crc4({2'b00, DAT}, 8), 13'h0000, 5'b11000};
        ecds = {5'b00001, 25'h0000000, DAT, ~crc4({2'b00, DAT}, 8), 1'b0,
            5'b00001};
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(negedge clk_sys);
        `CHECK(slo_out, 1'b1)
        `CHECK(bank_sel, 8'h00)
        `CHECK(wr_valid, 1'b0)
        $display("test reset done");
        repeat (3) @(posedge clk_sys);
        // Exactly 14 zero cycles, the shortest lead-in that opens a frame
        for (int n = 0; n < 62; n++) begin
            want = pos;
            fork
                mst.frame(n < 14 ? 1'b0 : cf[61 - n], cds, scd, crc, ok);
                begin
                    repeat (50) @(posedge clk_sys);
                    pos <= {pos[33:0], ~pos[34]};
                end
            join
            `CHECK(ok, 1'b1)
            `CHECK(scd, want)
            `CHECK(crc, ~crc6(want))
            `CHECK(cds, n < 14 ? 1'b0 : ecds[61 - n])
            // Only the first address bit has arrived here
            if (n == 19) begin
                `CHECK(bank_index, 6'h01)
            end
            if (n == 45) begin
                `CHECK(bank_index, ADR[5:0])
                `CHECK(wr_valid, 1'b1)
                `CHECK({wr_addr, wr_data}, {ADR, DAT})
                `CHECK(bank_sel, DAT)
                @(posedge clk_sys) wr_ready <= 1'b1;
                @(posedge clk_sys) wr_ready <= 1'b0;
                @(negedge clk_sys);
                `CHECK(wr_valid, 1'b0)
            end
        end
        $display("test cycles and write frame done");
        close_out();
    end
endmodule : test_biss_c_encoder_slave
bind biss_c_encoder_slave biss_slave_sva chk (
    .clk_sys, .resetn, .ma_in, .slo_out, .bank_sel,
    .wr_valid, .wr_ready, .wr_bank, .wr_addr, .wr_data
);
`default_nettype wire
